// ===== bmsg_top.sv
`timescale 1ns/100ps
`default_nettype none
module bmsg_top
  import bmsg_pkg::*;
(
  input wire logic sys_clk_i, // System clock 10 MHz
  input wire logic rst_n_i, // Async reset, active low
  input wire logic hsel, // AHB select
  input wire logic [31:0] haddr, // AHB address
  input wire logic [1:0] htrans, // AHB transfer type
  input wire logic hwrite, // AHB write
  input wire logic [2:0] hsize, // AHB size
  input wire logic [31:0] hwdata, // AHB write data
  input wire logic hready, // AHB ready in
  output logic [31:0] hrdata, // AHB read data
  output logic hreadyout, // AHB ready out
  output logic hresp, // AHB response
  input wire logic crystal_or_input_buffer_ref_i, // Crystal/buffer ref clock
  input wire logic clock_input_zero_i, // Reference clock 0
  input wire logic clock_input_one_i, // Reference clock 2
  input wire logic fracdiv1_clk_i, // Fractional divider 1 clock
  input wire logic fracdiv2_clk_i, // Fractional divider 2 clock
  output logic bank5_refin_clk_o, // Crystal ref to bank5 mux
  output logic [2:0] bank_ref2_clk_o, // Ref2 to banks 4..6
  output logic [2:0] bank_ref0_clk_o, // Ref0 to banks 4..6
  output logic [3:0] bank_fd2_clk_o, // Fracdiv2 to banks 3..6
  output logic [3:0] bank_fd1_clk_o // Fracdiv1 to banks 3..6
);
  // Bus phase capture
  logic wr_pend_reg;
  logic [11:0] addr_reg;
  logic [31:0] hrdata_reg;
  logic [31:0] gate_reg;
  logic [31:0] gate_next;
  logic [2:0] auto_reg;
  logic [14:0] route_reg;
  logic [31:0] live;
  logic [31:0] rd_mux;
  logic [2:0] hw_ref2;
  logic [2:0] hw_ref0;
  logic [2:0] hw_fd2;
  logic [2:0] hw_fd1;
  logic [2:0] own_ref2;
  logic [2:0] own_ref0;
  logic [2:0] own_fd2;
  logic [2:0] own_fd1;
  wire addr_ph = hsel & hready & htrans[1];
  wire rd_ph = addr_ph & ~hwrite;

  // Route word per bank: fanout mode [1:0], source sel [4:2]
  function automatic logic [1:0] fanout_of(input logic [14:0] r, input int b);
    fanout_of = r[b*5 +: 2];
  endfunction
  function automatic logic [2:0] src_of(input logic [14:0] r, input int b);
    src_of = r[b*5+2 +: 3];
  endfunction

  genvar g;
  generate
    for (g = 0; g < 3; g++)
    begin : g_bank
      assign own_ref2[g] = auto_reg[g] &
        (fanout_of(route_reg, g) == BMSG_FANOUT_REF2);
      assign own_ref0[g] = auto_reg[g] &
        (fanout_of(route_reg, g) == BMSG_FANOUT_REF0);
      assign own_fd2[g] = auto_reg[g] &
        (src_of(route_reg, g) == BMSG_SRC_FD2);
      assign own_fd1[g] = auto_reg[g] &
        (src_of(route_reg, g) == BMSG_SRC_FD1);
      assign hw_ref2[g] = own_ref2[g];
      assign hw_ref0[g] = own_ref0[g];
      assign hw_fd2[g] = own_fd2[g];
      assign hw_fd1[g] = own_fd1[g];
    end
  endgenerate

  // Effective gate: hardware-owned bits follow the mux selection
  always_comb
  begin
    live = gate_reg;
    for (int b = 0; b < 3; b++)
    begin
      if (own_ref2[b])
        live[BMSG_REF2_BIT + b] = hw_ref2[b];
      if (own_ref0[b])
        live[BMSG_REF0_BIT + b] = hw_ref0[b];
      if (own_fd2[b])
        live[BMSG_FD2_BIT + 1 + b] = hw_fd2[b];
      if (own_fd1[b])
        live[BMSG_FD1_BIT + 1 + b] = hw_fd1[b];
    end
  end

  // Writes to hardware-owned bits are dropped
  always_comb
  begin
    gate_next = gate_reg;
    if (wr_pend_reg && addr_reg == BMSG_GATE_OFFSET)
    begin
      gate_next = hwdata & BMSG_GATE_MASK;
      for (int b = 0; b < 3; b++)
      begin
        if (own_ref2[b])
          gate_next[BMSG_REF2_BIT + b] = gate_reg[BMSG_REF2_BIT + b];
        if (own_ref0[b])
          gate_next[BMSG_REF0_BIT + b] = gate_reg[BMSG_REF0_BIT + b];
        if (own_fd2[b])
          gate_next[BMSG_FD2_BIT+1+b] = gate_reg[BMSG_FD2_BIT+1+b];
        if (own_fd1[b])
          gate_next[BMSG_FD1_BIT+1+b] = gate_reg[BMSG_FD1_BIT+1+b];
      end
    end
  end

  always_comb
  begin
    unique case (haddr[11:0])
      BMSG_GATE_OFFSET: rd_mux = gate_reg;
      BMSG_AUTO_OFFSET: rd_mux = {29'h0, auto_reg};
      BMSG_ROUTE_OFFSET: rd_mux = {17'h0, route_reg};
      BMSG_LIVE_OFFSET: rd_mux = live;
      default: rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr_pend_reg <= 1'b0;
      addr_reg <= 12'h000;
      hrdata_reg <= 32'h0;
    end
    else
    begin
      wr_pend_reg <= addr_ph & hwrite;
      if (addr_ph)
        addr_reg <= haddr[11:0];
      if (rd_ph)
        hrdata_reg <= rd_mux;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      gate_reg <= BMSG_GATE_RESET;
      auto_reg <= BMSG_AUTO_RESET;
      route_reg <= BMSG_ROUTE_RESET;
    end
    else
    begin
      gate_reg <= gate_next;
      if (wr_pend_reg && addr_reg == BMSG_AUTO_OFFSET)
        auto_reg <= hwdata[2:0];
      if (wr_pend_reg && addr_reg == BMSG_ROUTE_OFFSET)
        route_reg <= hwdata[14:0];
    end
  end

  assign hrdata = hrdata_reg;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  bmsg_clk_gate u_refin
  (
    .clk_i(crystal_or_input_buffer_ref_i),
    .en_i(live[BMSG_REFIN_BIT]),
    .clk_o(bank5_refin_clk_o)
  );
  generate
    for (g = 0; g < 3; g++)
    begin : g_ref
      bmsg_clk_gate u_r2
      (
        .clk_i(clock_input_one_i),
        .en_i(live[BMSG_REF2_BIT + g]),
        .clk_o(bank_ref2_clk_o[g])
      );
      bmsg_clk_gate u_r0
      (
        .clk_i(clock_input_zero_i),
        .en_i(live[BMSG_REF0_BIT + g]),
        .clk_o(bank_ref0_clk_o[g])
      );
    end
    for (g = 0; g < 4; g++)
    begin : g_fd
      bmsg_clk_gate u_f2
      (
        .clk_i(fracdiv2_clk_i),
        .en_i(live[BMSG_FD2_BIT + g]),
        .clk_o(bank_fd2_clk_o[g])
      );
      bmsg_clk_gate u_f1
      (
        .clk_i(fracdiv1_clk_i),
        .en_i(live[BMSG_FD1_BIT + g]),
        .clk_o(bank_fd1_clk_o[g])
      );
    end
  endgenerate

  // Reset value of every gate bit
  AST_GATE_RESET: assert property (
    @(posedge sys_clk_i) $rose(rst_n_i) |-> gate_reg == BMSG_GATE_RESET)
    else $error("gate reset value wrong");
  AST_REF2_IGNORE: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    own_ref2[0] && $stable(own_ref2[0]) |-> $stable(gate_reg[BMSG_REF2_BIT]))
    else $error("ref2 bank4 bit changed while owned");
  AST_REF0_IGNORE: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    $past(own_ref0[1]) |-> $stable(gate_reg[BMSG_REF0_BIT + 1]))
    else $error("ref0 bank5 bit changed while owned");
  AST_FD2_IGNORE: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    $past(own_fd2[2]) |-> $stable(gate_reg[BMSG_FD2_BIT + 3]))
    else $error("fracdiv2 bank6 bit changed while owned");
  AST_FD1_IGNORE: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    $past(own_fd1[0]) |-> $stable(gate_reg[BMSG_FD1_BIT + 1]))
    else $error("fracdiv1 bank4 bit changed while owned");
  AST_FD2_B3_FREE: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    wr_pend_reg && addr_reg == BMSG_GATE_OFFSET
    |=> gate_reg[BMSG_FD2_BIT] == $past(hwdata[BMSG_FD2_BIT]))
    else $error("fracdiv2 bank3 write lost");
  AST_FD1_B3_FREE: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    wr_pend_reg && addr_reg == BMSG_GATE_OFFSET
    |=> gate_reg[BMSG_FD1_BIT] == $past(hwdata[BMSG_FD1_BIT]))
    else $error("fracdiv1 bank3 write lost");
  AST_REF0_WRITE: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    wr_pend_reg && addr_reg == BMSG_GATE_OFFSET && !own_ref0[2]
    |=> gate_reg[BMSG_REF0_BIT + 2] == $past(hwdata[BMSG_REF0_BIT + 2]))
    else $error("ref0 bank6 write lost");
  AST_REF2_WRITE: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    wr_pend_reg && addr_reg == BMSG_GATE_OFFSET && !own_ref2[1]
    |=> gate_reg[BMSG_REF2_BIT + 1] == $past(hwdata[BMSG_REF2_BIT + 1]))
    else $error("ref2 bank5 write lost");
  // Gate shut while its source sat low, so the latch holds it closed
  sequence refin_shut_s;
    !live[BMSG_REFIN_BIT] && !crystal_or_input_buffer_ref_i
    ##1 !live[BMSG_REFIN_BIT];
  endsequence
  AST_LOW_WHEN_OFF: assert property (
    @(posedge sys_clk_i) disable iff (!rst_n_i)
    refin_shut_s |-> !bank5_refin_clk_o)
    else $error("closed gate leaks clock");
endmodule
`default_nettype wire

// ===== bmsg_pkg.sv
`default_nettype none
package bmsg_pkg;
  localparam logic [11:0] BMSG_GATE_OFFSET = 12'h000;
  localparam logic [11:0] BMSG_AUTO_OFFSET = 12'h004;
  localparam logic [11:0] BMSG_ROUTE_OFFSET = 12'h008;
  localparam logic [11:0] BMSG_LIVE_OFFSET = 12'h00c;
  localparam logic [31:0] BMSG_GATE_RESET = 32'hfffe0000;
  localparam logic [31:0] BMSG_GATE_MASK = 32'hfffe0000;
  localparam int BMSG_REFIN_BIT = 31;
  localparam int BMSG_REF2_BIT = 28;
  localparam int BMSG_REF0_BIT = 25;
  localparam int BMSG_FD2_BIT = 21;
  localparam int BMSG_FD1_BIT = 17;
  localparam logic [1:0] BMSG_FANOUT_REF2 = 2'h2;
  localparam logic [1:0] BMSG_FANOUT_REF0 = 2'h1;
  localparam logic [2:0] BMSG_SRC_FD2 = 3'h6;
  localparam logic [2:0] BMSG_SRC_FD1 = 3'h5;
  localparam logic [2:0] BMSG_AUTO_RESET = 3'h0;
  localparam logic [14:0] BMSG_ROUTE_RESET = 15'h0000;
endpackage
`default_nettype wire

// ===== bmsg_clk_gate.sv
`timescale 1ns/100ps
`default_nettype none
module bmsg_clk_gate
(
  input wire logic clk_i, // Source clock
  input wire logic en_i, // Gate open
  output logic clk_o // Gated clock, low when closed
);
  logic latch_en;
  always_latch
  begin
    if (!clk_i)
      latch_en = en_i;
  end
  assign clk_o = clk_i & latch_en;
endmodule
`default_nettype wire

// ===== bmsg_tb.sv
`timescale 1ns/100ps
`default_nettype none
module testbench
  import bmsg_pkg::*;
;
  logic sys_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [4:0] src = 5'h00;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic refin_o;
  logic [2:0] ref2_o;
  logic [2:0] ref0_o;
  logic [3:0] fd2_o;
  logic [3:0] fd1_o;
  logic [31:0] rd;
  int fail_count = 0;
  int check_count = 0;
  int cyc = 0;
  wire logic [31:0] outs = {refin_o, ref2_o, ref0_o, fd2_o, fd1_o, 17'h0};

  bmsg_top bmsg_top_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp),
    .crystal_or_input_buffer_ref_i(src[0]), .clock_input_zero_i(src[1]),
    .clock_input_one_i(src[2]), .fracdiv1_clk_i(src[3]),
    .fracdiv2_clk_i(src[4]), .bank5_refin_clk_o(refin_o),
    .bank_ref2_clk_o(ref2_o), .bank_ref0_clk_o(ref0_o),
    .bank_fd2_clk_o(fd2_o), .bank_fd1_clk_o(fd1_o));

  always #50 sys_clk_i = ~sys_clk_i;

  always @(posedge sys_clk_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      fail_count++;
      close_out();
    end
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask

  task automatic xfer(input logic w, input logic [31:0] a,
                      input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge sys_clk_i); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sys_clk_i); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("response", 32'h0, {31'h0, hresp});
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, {20'h0, a}, d);
  endtask

  task automatic rchk(input string what, input logic [11:0] a,
                      input logic [31:0] exp);
    xfer(1'b0, {20'h0, a}, 32'h0);
    chk(what, exp, rd);
  endtask

  // Pulse sources low then high so the enable latches refresh
  task automatic show(input string what, input logic [31:0] exp);
    src <= 5'h00;
    @(posedge sys_clk_i);
    #1;
    chk({what, " low"}, 32'h0, outs);
    @(posedge sys_clk_i);
    src <= 5'h1f;
    #1;
    chk(what, exp, outs);
    @(posedge sys_clk_i);
  endtask

  initial
  begin
    repeat (4) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    @(posedge sys_clk_i);
    rchk("gate reset", BMSG_GATE_OFFSET, BMSG_GATE_RESET);
    rchk("auto reset", BMSG_AUTO_OFFSET, 32'h0);
    rchk("route reset", BMSG_ROUTE_OFFSET, 32'h0);
    rchk("live reset", BMSG_LIVE_OFFSET, BMSG_GATE_RESET);
    show("outs reset", BMSG_GATE_RESET);
    $display("test reset done");
    for (int i = 17; i < 32; i++)
    begin
      wr(BMSG_GATE_OFFSET, 32'h1 << i);
      rchk("gate bit", BMSG_GATE_OFFSET, 32'h1 << i);
      show("outs bit", 32'h1 << i);
    end
    wr(BMSG_GATE_OFFSET, 32'hffffffff);
    rchk("gate mask", BMSG_GATE_OFFSET, BMSG_GATE_MASK);
    wr(BMSG_GATE_OFFSET, 32'h0);
    show("outs closed", 32'h0);
    $display("test walk done");
    wr(BMSG_ROUTE_OFFSET, 32'h00006b5a);
    wr(BMSG_AUTO_OFFSET, 32'h7);
    rchk("live ref2 fd2", BMSG_LIVE_OFFSET, 32'h71c00000);
    show("outs ref2 fd2", 32'h71c00000);
    wr(BMSG_GATE_OFFSET, 32'hffffffff);
    rchk("gate owned", BMSG_GATE_OFFSET, 32'h8e3e0000);
    wr(BMSG_AUTO_OFFSET, 32'h2);
    rchk("live bank5", BMSG_LIVE_OFFSET, 32'haebe0000);
    wr(BMSG_AUTO_OFFSET, 32'h0);
    wr(BMSG_GATE_OFFSET, 32'h0);
    wr(BMSG_ROUTE_OFFSET, 32'h000056b5);
    wr(BMSG_AUTO_OFFSET, 32'h7);
    rchk("live ref0 fd1", BMSG_LIVE_OFFSET, 32'h0e1c0000);
    show("outs ref0 fd1", 32'h0e1c0000);
    wr(BMSG_AUTO_OFFSET, 32'h0);
    rchk("live released", BMSG_LIVE_OFFSET, 32'h0);
    $display("test auto done");
    wr(12'h010, 32'hffffffff);
    rchk("unmapped", 12'h010, 32'h0);
    wr(BMSG_LIVE_OFFSET, 32'hffffffff);
    rchk("live ro", BMSG_LIVE_OFFSET, 32'h0);
    rchk("gate kept", BMSG_GATE_OFFSET, 32'h0);
    $display("test refuse done");
    wr(BMSG_AUTO_OFFSET, 32'h7);
    @(posedge sys_clk_i);
    rst_n_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    @(posedge sys_clk_i);
    rchk("auto again", BMSG_AUTO_OFFSET, 32'h0);
    rchk("route again", BMSG_ROUTE_OFFSET, 32'h0);
    rchk("live again", BMSG_LIVE_OFFSET, BMSG_GATE_RESET);
    show("outs again", BMSG_GATE_RESET);
    $display("test reset again done");
    close_out();
  end
endmodule
`default_nettype wire
